// ==== dv/medsc_asserts.sv ====
// Checker: port-level properties of the memory error control block
`timescale 1ns/10ps
`default_nettype none

module medsc_asserts #(
    parameter int unsigned DEPTH = 16  // Words per memory
) (
    input wire logic                   clk_i,     // System clock
    input wire logic                   rstn_i,    // System reset, low
    input wire logic                   porn_i,    // Power-on reset, low
    input wire logic                   psel_i,    // APB select
    input wire logic                   penable_i, // APB enable
    input wire logic                   pwrite_i,  // APB direction
    input wire logic [11:0]            paddr_i,   // APB address
    input wire logic [31:0]            pwdata_i,  // APB write data
    input wire logic [31:0]            prdata_o,  // APB read data
    input wire logic                   pready_o,  // APB ready
    input wire logic                   pslverr_o, // APB error
    input wire medsc_pkg::medsc_mreq_t mreq_i,    // Memory request
    input wire medsc_pkg::medsc_mrsp_t mrsp_o,    // Memory answer
    input wire logic                   irq_o      // Error interrupt
);
    import medsc_pkg::*;

    logic       rst_n;    // Either reset low
    logic       allow_sh; // Shadow of the code write-allow bit
    logic [3:0] irqen_sh; // Shadow of the interrupt enable
    logic       wr_done;  // APB write completes this edge
    logic       code_wr;  // Request is a code memory write

    // Reset and request decode
    assign rst_n   = rstn_i && porn_i;
    assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
    assign code_wr = mreq_i.req && mreq_i.we && mreq_i.sel == MEM_CODE;

    // Write-allow shadow, cleared by any reset
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) allow_sh <= 1'b0;
        else if (wr_done && paddr_i == OFF_WPROT) allow_sh <= pwdata_i[0];
    end

    // Enable shadow survives system reset, power-on only clears it
    always_ff @(posedge clk_i or negedge porn_i) begin
        if (!porn_i) irqen_sh <= 4'h0;
        else if (wr_done && paddr_i == OFF_IRQEN) irqen_sh <= pwdata_i[3:0];
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_rd(logic [11:0] a);
        psel_i && !penable_i && !pwrite_i && paddr_i == a;
    endsequence

    property p_ready;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("no ready after setup");

    property p_ready_cause;
        pready_o |-> $past(psel_i) && !$past(penable_i);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without setup");

    property p_unmapped;
        psel_i && !penable_i && paddr_i > OFF_IRQSTAT |=>
            pslverr_o && prdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_fault;
        code_wr && !allow_sh |=> mrsp_o.fault && mrsp_o.ack;
    endproperty
    a_fault: assert property (p_fault)
        else $error("blocked code write did not fault");

    property p_fault_cause;
        mrsp_o.fault |-> $past(code_wr) && !$past(allow_sh);
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault without blocked write");

    property p_allow_rd;
        s_rd(OFF_WPROT) |=> prdata_o == {31'h0, allow_sh};
    endproperty
    a_allow_rd: assert property (p_allow_rd)
        else $error("write-allow read wrong");

    property p_scrub_rsv;
        (s_rd(OFF_CSCRUB) or s_rd(OFF_DSCRUB)) |=> prdata_o[31:24] == 8'h00;
    endproperty
    a_scrub_rsv: assert property (p_scrub_rsv)
        else $error("scrub upper bits not zero");

    property p_synd_rsv;
        (s_rd(OFF_CTRAPS) or s_rd(OFF_DTRAPS)) |=> prdata_o[31:20] == 12'h000;
    endproperty
    a_synd_rsv: assert property (p_synd_rsv)
        else $error("check bits upper field not zero");

    property p_irqen_rd;
        s_rd(OFF_IRQEN) |=> prdata_o == {28'h0, irqen_sh};
    endproperty
    a_irqen_rd: assert property (p_irqen_rd)
        else $error("interrupt enable lost or wrong");

    property p_irq_mask;
        $past(irqen_sh) == 4'h0 |-> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt while all sources masked");

endmodule : medsc_asserts

bind medsc_top medsc_asserts #(.DEPTH(DEPTH)) medsc_asserts_i (
    .clk_i, .rstn_i, .porn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mreq_i, .mrsp_o, .irq_o
);

`default_nettype wire

// ==== dv/testbench.sv ====
// Testbench: self-checking bench for the memory error control block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import medsc_pkg::*;

    typedef struct {
        logic [11:0] a; // Register address
        logic [31:0] d; // Value written
        logic [31:0] x; // Value read back
        logic        e; // Error expected
    } medsc_row_t;

    logic        clk_i     = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        porn_i    = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    medsc_mreq_t mreq_i    = '0;
    medsc_mrsp_t mrsp_o;
    logic        irq_o;
    int          mismatches = 0;
    int          cmp_count  = 0;
    logic [31:0] rd;
    logic        er;
    medsc_mrsp_t rsp;

    // Register table: written value and expected read-back
    medsc_row_t rows [10] = '{
        '{OFF_WPROT,  32'hFFFF_FFFF, 32'h0000_0001, 1'b0},
        '{OFF_CSCRUB, 32'hFFFF_FFFF, 32'h00FF_FFFF, 1'b0},
        '{OFF_DSCRUB, 32'hFFFF_FFFF, 32'h00FF_FFFF, 1'b0},
        '{OFF_CTRAPA, 32'hFFFF_FFFF, 32'hFFFF_FFFC, 1'b0},
        '{OFF_CTRAPS, 32'hFFFF_FFFF, 32'h000F_FFFF, 1'b0},
        '{OFF_DTRAPA, 32'hFFFF_FFFF, 32'hFFFF_FFFC, 1'b0},
        '{OFF_DTRAPS, 32'hFFFF_FFFF, 32'h000F_FFFF, 1'b0},
        '{OFF_IRQEN,  32'hFFFF_FFFF, 32'h0000_000F, 1'b0},
        '{12'h100,    32'hFFFF_FFFF, 32'h0,         1'b1},
        '{12'h006,    32'hFFFF_FFFF, 32'h0,         1'b1}
    };

    medsc_top #(.DEPTH(4)) medsc_top_i (
        .clk_i, .rstn_i, .porn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mreq_i, .mrsp_o, .irq_o
    );

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    ////////////////////////////////////////
    // Compare one value and count it
    task automatic chk(input string n, input logic [31:0] s, x);
        cmp_count++;
        if (s !== x) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    // Print the counts and the verdict, then stop
    task automatic results();
        $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // One APB transfer, held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (pready_o !== 1'b1) begin
            mismatches++;
            results();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // One memory request, answer taken in the following cycle
    task automatic mem(input logic w, s, input logic [31:0] a, d);
        @(posedge clk_i);
        mreq_i <= '{req: 1'b1, we: w, sel: s, addr: a, wdata: d};
        @(posedge clk_i);
        mreq_i.req <= 1'b0;
        @(posedge clk_i);
        rsp = mrsp_o;
    endtask : mem

    // Hold reset five cycles, then wait out the synchronizer
    task automatic pulse(input logic por);
        rstn_i <= 1'b0;
        porn_i <= !por;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        porn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : pulse

    ////////////////////////////////////////
    initial begin
        pulse(1'b1);
        apb(1'b0, OFF_WPROT, 32'h0);
        chk("wprot reset", rd, 32'h0);
        apb(1'b1, OFF_WPROT, 32'h1);
        for (int i = 0; i < 8; i++) begin
            mem(1'b1, i[2], 32'(i[1:0]) << 2, 32'h0);
        end
        apb(1'b1, OFF_WPROT, 32'h0);
        foreach (rows[k]) begin
            apb(1'b0, rows[k].a, 32'h0);
            chk("reset value", rd, 32'h0);
            apb(1'b1, rows[k].a, rows[k].d);
            apb(1'b0, rows[k].a, 32'h0);
            chk("read back", rd, rows[k].x);
            chk("error flag", {31'h0, er}, {31'h0, rows[k].e});
            apb(1'b1, rows[k].a, 32'h0);
        end
        $display("Register table done");
        // Blocked code write faults and leaves the word intact
        mem(1'b1, MEM_CODE, 32'h4, 32'hDEAD_BEEF);
        chk("fault", {30'h0, rsp.fault, rsp.ack}, 32'h3);
        mem(1'b0, MEM_CODE, 32'h4, 32'h0);
        chk("kept word", rsp.rdata, 32'h0);
        mem(1'b1, MEM_DATA, 32'h4, 32'hDEAD_BEEF);
        chk("data fault", {31'h0, rsp.fault}, 32'h0);
        $display("Write protect done");
        // Traps: double error in code word 2, single in data word 1
        apb(1'b1, OFF_WPROT, 32'h1);
        apb(1'b1, OFF_CTRAPS, 32'h3);
        apb(1'b1, OFF_CTRAPA, 32'hC000_0008);
        apb(1'b1, OFF_DTRAPS, 32'h1);
        apb(1'b1, OFF_DTRAPA, 32'h8000_0004);
        mem(1'b1, MEM_CODE, 32'h8, 32'h0);
        mem(1'b1, MEM_CODE, 32'hC, 32'h0);
        mem(1'b1, MEM_DATA, 32'h4, 32'h0);
        mem(1'b0, MEM_CODE, 32'h8, 32'h0);
        chk("code mbe", {31'h0, rsp.mbe}, 32'h1);
        mem(1'b0, MEM_CODE, 32'hC, 32'h0);
        chk("no trap", {30'h0, rsp.sbe, rsp.mbe}, 32'h0);
        mem(1'b0, MEM_DATA, 32'h4, 32'h0);
        chk("data sbe", {31'h0, rsp.sbe}, 32'h1);
        chk("corrected", rsp.rdata, 32'h0);
        $display("Trap done");
        // Masked events keep the line low; enabling raises it
        repeat (2) @(posedge clk_i);
        chk("masked irq", {31'h0, irq_o}, 32'h0);
        apb(1'b1, OFF_IRQEN, 32'hF);
        repeat (2) @(posedge clk_i);
        chk("irq", {31'h0, irq_o}, 32'h1);
        apb(1'b0, OFF_IRQSTAT, 32'h0);
        chk("status", rd, 32'h9);
        repeat (2) @(posedge clk_i);
        chk("irq clear", {31'h0, irq_o}, 32'h0);
        $display("Interrupt done");
        // Scrub finds the planted error, again after wrapping, then stops
        apb(1'b1, OFF_DSCRUB, 32'h00FF_FFFF);
        apb(1'b1, OFF_DSCRUB, 32'h8000_0003);
        repeat (40) @(posedge clk_i);
        apb(1'b0, OFF_IRQSTAT, 32'h0);
        chk("scrub sbe", rd, 32'h1);
        mem(1'b1, MEM_DATA, 32'h4, 32'h0);
        repeat (40) @(posedge clk_i);
        apb(1'b0, OFF_IRQSTAT, 32'h0);
        chk("after wrap", rd, 32'h1);
        apb(1'b1, OFF_DSCRUB, 32'h0);
        mem(1'b0, MEM_DATA, 32'h4, 32'h0);
        chk("written back", {31'h0, rsp.sbe}, 32'h0);
        mem(1'b1, MEM_DATA, 32'h4, 32'h0);
        repeat (40) @(posedge clk_i);
        apb(1'b0, OFF_IRQSTAT, 32'h0);
        chk("scrub off", rd, 32'h0);
        $display("Scrub done");
        // System reset keeps the enable; power-on clears it
        pulse(1'b0);
        apb(1'b0, OFF_IRQEN, 32'h0);
        chk("irqen kept", rd, 32'hF);
        apb(1'b0, OFF_WPROT, 32'h0);
        chk("wprot cleared", rd, 32'h0);
        pulse(1'b1);
        apb(1'b0, OFF_IRQEN, 32'h0);
        chk("irqen cleared", rd, 32'h0);
        $display("Reset done");
        results();
    end

endmodule : testbench

`default_nettype wire

// ==== rtl/medsc_pkg.sv ====
// Package: constants and carriers for the memory error control block
package medsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CHK_W    = 5;   // Check bits per byte
    localparam int unsigned BYTES    = 4;
    localparam int unsigned SYN_W    = CHK_W * BYTES;
    localparam int unsigned RELOAD_W = 24;
    localparam int unsigned PADDR_W  = 12;
    localparam int unsigned IRQ_W    = 4;
    localparam int unsigned NMEM     = 2;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] OFF_WPROT   = 12'h000;
    localparam logic [11:0] OFF_CSCRUB  = 12'h004;
    localparam logic [11:0] OFF_DSCRUB  = 12'h008;
    localparam logic [11:0] OFF_CTRAPA  = 12'h00C;
    localparam logic [11:0] OFF_CTRAPS  = 12'h010;
    localparam logic [11:0] OFF_DTRAPA  = 12'h014;
    localparam logic [11:0] OFF_DTRAPS  = 12'h018;
    localparam logic [11:0] OFF_IRQEN   = 12'h01C;
    localparam logic [11:0] OFF_IRQSTAT = 12'h020;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and masks
    localparam int unsigned WALLOW_BIT  = 0;
    localparam int unsigned RESTART_BIT = 31;
    localparam int unsigned TRAP_EN_BIT = 31;
    localparam int unsigned TRAP_LO     = 2;
    localparam int unsigned TRAP_HI     = 30;
    localparam logic [31:0] TRAP_MASK   = 32'hFFFF_FFFC;
    localparam int unsigned IRQ_DSB     = 0;
    localparam int unsigned IRQ_DMB     = 1;
    localparam int unsigned IRQ_CSB     = 2;
    localparam int unsigned IRQ_CMB     = 3;

    // Memory selector values
    localparam logic MEM_CODE = 1'b0;
    localparam logic MEM_DATA = 1'b1;

    // Codeword positions of data bits 7..0 in a 12-bit Hamming word
    localparam logic [31:0] HAM_POS = 32'hCBA9_7653;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic        req;
        logic        we;
        logic        sel;
        logic [31:0] addr;
        logic [31:0] wdata;
    } medsc_mreq_t;

    typedef struct packed {
        logic        ack;
        logic        fault;
        logic        sbe;
        logic        mbe;
        logic [31:0] rdata;
    } medsc_mrsp_t;

    typedef struct packed {
        logic        sbe;
        logic        mbe;
        logic [31:0] d;
        logic [19:0] c;
    } medsc_chk_t;

endpackage : medsc_pkg

// ==== rtl/medsc_top.sv ====
// Module: protected code/data memories with scrub, trap and error interrupt
//
// Behaviour
// - A code memory write while writes are not allowed is dropped and faults.
// - The write-allow control is bit 0, resets to 0, 0 protects, 1 allows.
// - The code scrub reload is bits 23:0, resets to 0, and 0 stops scrubbing.
// - A non-zero reload counts down, reloads at zero and issues one request.
// - Each request checks one 32-bit word and steps the scrub address.
// - Writing 1 to bit 31 of a scrub register restarts its counter.
// - The data memory has its own identical scrub counter and address.
// - An enabled trap whose address matches a write stores the trap checks.
// - The trap match uses bits 30:2 but only those that index the memory.
// - Trap check bits sit per byte at 4:0, 9:5, 14:10, 19:15, reset 0.
// - The data memory has its own trap address and trap check bits.
// - Interrupt enable bit 0 gates data single-bit errors, reset 0.
// - The interrupt enable is cleared by power-on reset only.
// - Scrub register bits 30:24 and bit 31 read as zero.
// - Enable bits 1, 2, 3 gate data multi, code single, code multi.
`timescale 1ns/10ps
`default_nettype none

module medsc_top #(
    parameter int unsigned DEPTH = 16  // Words per memory
) (
    input  wire logic                  clk_i,     // System clock
    input  wire logic                  rstn_i,    // System reset, low
    input  wire logic                  porn_i,    // Power-on reset, low
    input  wire logic                  psel_i,    // APB select
    input  wire logic                  penable_i, // APB enable
    input  wire logic                  pwrite_i,  // APB direction
    input  wire logic [11:0]           paddr_i,   // APB address
    input  wire logic [31:0]           pwdata_i,  // APB write data
    output logic      [31:0]           prdata_o,  // APB read data
    output logic                       pready_o,  // APB ready
    output logic                       pslverr_o, // APB error
    input  wire medsc_pkg::medsc_mreq_t mreq_i,   // Memory request
    output var  medsc_pkg::medsc_mrsp_t mrsp_o,   // Memory answer
    output logic                       irq_o      // Error interrupt
);
    import medsc_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);

    if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0) || (AW > 29)) begin : g_chk
        $error("DEPTH must be a power of two from 2 to 2**29");
    end

    ////////////////////////////////////////////////////////////////////////
    // Check bit functions

    // Five check bits of one byte: four Hamming bits and overall parity
    function automatic logic [4:0] enc8(input logic [7:0] d);
        logic [3:0] c;
        c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        return {^{d, c}, c};
    endfunction : enc8

    // Check bits of a whole word, byte 0 lowest
    function automatic logic [19:0] enc_word(input logic [31:0] d);
        logic [19:0] c;
        c = '0;
        for (int b = 0; b < BYTES; b++) begin
            c[CHK_W*b +: CHK_W] = enc8(d[8*b +: 8]);
        end
        return c;
    endfunction : enc_word

    // Checks a stored word, corrects single errors per byte
    function automatic medsc_chk_t check_word(input logic [31:0] d,
                                              input logic [19:0] c);
        medsc_chk_t r;
        logic [4:0] e;
        logic [3:0] s;
        logic       p;
        r = '{sbe: 1'b0, mbe: 1'b0, d: d, c: c};
        for (int b = 0; b < BYTES; b++) begin
            e = enc8(d[8*b +: 8]);
            s = e[3:0] ^ c[CHK_W*b +: 4];
            p = ^{d[8*b +: 8], c[CHK_W*b +: CHK_W]};
            if (p) begin
                r.sbe = 1'b1;
                for (int i = 0; i < 8; i++) begin
                    if (s == HAM_POS[4*i +: 4]) begin
                        r.d[8*b+i] = ~d[8*b+i];
                    end
                end
            end else if (s != 4'h0) begin
                r.mbe = 1'b1;
            end
        end
        r.c = enc_word(r.d);
        return r;
    endfunction : check_word

    ////////////////////////////////////////////////////////////////////////
    // Reset synchronisers

    logic [1:0] por_q;
    logic [1:0] rst_q;
    logic       por_n;
    logic       rst_n;

    // Power-on copy, released through two flops
    always_ff @(posedge clk_i or negedge porn_i) begin
        if (!porn_i) begin
            por_q <= 2'h0;
        end else begin
            por_q <= {por_q[0], 1'b1};
        end
    end

    // System copy, also held by power-on reset
    always_ff @(posedge clk_i or negedge rstn_i or negedge porn_i) begin
        if (!rstn_i || !porn_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    assign por_n = por_q[1];
    assign rst_n = rst_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                wr_allow;
    logic [23:0]         reload   [NMEM];
    logic                restart  [NMEM];
    logic [31:0]         trap_adr [NMEM];
    logic [19:0]         trap_syn [NMEM];
    logic [3:0]          irq_en;
    logic [3:0]          irq_stat;
    logic [23:0]         cnt      [NMEM];
    logic                pend     [NMEM];
    logic [AW-1:0]       saddr    [NMEM];
    logic                go       [NMEM];
    medsc_chk_t          schk     [NMEM];
    logic [31:0]         mem_d    [NMEM][DEPTH];
    logic [19:0]         mem_c    [NMEM][DEPTH];
    logic                sev      [NMEM];
    logic                mev      [NMEM];
    logic [3:0]          ev;
    logic                apb_wr;
    logic                apb_rd;
    logic [31:0]         rmux;
    logic                hit;
    logic [AW-1:0]       uidx;
    logic                ublock;
    logic                uwr;
    logic                urd;
    logic                trap_hit;
    logic [19:0]         uchk;
    medsc_chk_t          ures;

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign apb_rd = psel_i & penable_i & pready_o & ~pwrite_i;

    // Read multiplexer; unused bits read as zero
    always_comb begin
        rmux = 32'h0000_0000;
        hit  = 1'b1;
        case (paddr_i)
            OFF_WPROT:   rmux[WALLOW_BIT] = wr_allow;
            OFF_CSCRUB:  rmux = 32'(reload[MEM_CODE]);
            OFF_DSCRUB:  rmux = 32'(reload[MEM_DATA]);
            OFF_CTRAPA:  rmux = trap_adr[MEM_CODE];
            OFF_CTRAPS:  rmux = 32'(trap_syn[MEM_CODE]);
            OFF_DTRAPA:  rmux = trap_adr[MEM_DATA];
            OFF_DTRAPS:  rmux = 32'(trap_syn[MEM_DATA]);
            OFF_IRQEN:   rmux = 32'(irq_en);
            OFF_IRQSTAT: rmux = 32'(irq_stat);
            default:     hit  = 1'b0;
        endcase
    end

    // One wait-free answer: ready in the access phase
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~hit;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rmux
                                                           : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Write-allow switch
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_allow <= 1'b0;
        end else if (apb_wr && paddr_i == OFF_WPROT) begin
            wr_allow <= pwdata_i[WALLOW_BIT];
        end
    end

    // Scrub reloads and restart pulses
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reload  <= '{default: '0};
            restart <= '{default: 1'b0};
        end else begin
            restart <= '{default: 1'b0};
            if (apb_wr && paddr_i == OFF_CSCRUB) begin
                reload[MEM_CODE]  <= pwdata_i[RELOAD_W-1:0];
                restart[MEM_CODE] <= pwdata_i[RESTART_BIT];
            end
            if (apb_wr && paddr_i == OFF_DSCRUB) begin
                reload[MEM_DATA]  <= pwdata_i[RELOAD_W-1:0];
                restart[MEM_DATA] <= pwdata_i[RESTART_BIT];
            end
        end
    end

    // Trap address and check bits, one pair per memory
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            trap_adr <= '{default: '0};
            trap_syn <= '{default: '0};
        end else if (apb_wr) begin
            case (paddr_i)
                OFF_CTRAPA: trap_adr[MEM_CODE] <= pwdata_i & TRAP_MASK;
                OFF_CTRAPS: trap_syn[MEM_CODE] <= pwdata_i[SYN_W-1:0];
                OFF_DTRAPA: trap_adr[MEM_DATA] <= pwdata_i & TRAP_MASK;
                OFF_DTRAPS: trap_syn[MEM_DATA] <= pwdata_i[SYN_W-1:0];
                default:    ;
            endcase
        end
    end

    // Interrupt enable survives every reset but power-on
    always_ff @(posedge clk_i or negedge por_n) begin
        if (!por_n) begin
            irq_en <= 4'h0;
        end else if (apb_wr && paddr_i == OFF_IRQEN) begin
            irq_en <= pwdata_i[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Background scrubbers, one per memory

    for (genvar m = 0; m < NMEM; m++) begin : g_scrub
        // Scrub waits while the user port owns this memory
        assign go[m] = pend[m] & ~(mreq_i.req & (mreq_i.sel == 1'(m)));
        assign schk[m] = check_word(mem_d[m][saddr[m]], mem_c[m][saddr[m]]);

        // Countdown, request and address stepping
        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                cnt[m]   <= '0;
                pend[m]  <= 1'b0;
                saddr[m] <= '0;
            end else begin
                if (reload[m] == '0) begin
                    cnt[m] <= '0;
                end else if (restart[m] || cnt[m] == '0) begin
                    cnt[m] <= reload[m];
                end else begin
                    cnt[m] <= cnt[m] - 24'h000001;
                end
                pend[m] <= (reload[m] != '0 && !restart[m] &&
                            cnt[m] == '0) || (pend[m] && !go[m]);
                if (go[m]) begin
                    saddr[m] <= (saddr[m] == AW'(DEPTH - 1)) ? '0
                              : saddr[m] + AW'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User port

    assign uidx   = mreq_i.addr[AW+1:2];
    assign ublock = mreq_i.req & mreq_i.we & (mreq_i.sel == MEM_CODE) &
                    ~wr_allow;
    assign uwr    = mreq_i.req & mreq_i.we & ~ublock;
    assign urd    = mreq_i.req & ~mreq_i.we;
    // Only the bits that index the memory are compared
    assign trap_hit = trap_adr[mreq_i.sel][TRAP_EN_BIT] &&
        trap_adr[mreq_i.sel][AW+1:TRAP_LO] == uidx;
    assign uchk = trap_hit ? trap_syn[mreq_i.sel]
                           : enc_word(mreq_i.wdata);
    assign ures = check_word(mem_d[mreq_i.sel][uidx],
                             mem_c[mreq_i.sel][uidx]);

    // Memory array writes; no reset on storage
    always_ff @(posedge clk_i) begin
        for (int m = 0; m < NMEM; m++) begin
            if (go[m] && schk[m].sbe && !schk[m].mbe) begin
                mem_d[m][saddr[m]] <= schk[m].d;
                mem_c[m][saddr[m]] <= schk[m].c;
            end
        end
        if (uwr) begin
            mem_d[mreq_i.sel][uidx] <= mreq_i.wdata;
            mem_c[mreq_i.sel][uidx] <= uchk;
        end
    end

    // Answer to the user port one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mrsp_o <= '0;
        end else begin
            mrsp_o.ack   <= mreq_i.req;
            mrsp_o.fault <= ublock;
            mrsp_o.sbe   <= urd & ures.sbe & ~ures.mbe;
            mrsp_o.mbe   <= urd & ures.mbe;
            mrsp_o.rdata <= urd ? ures.d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error events and interrupt

    // Events from scrubbers and user reads
    always_comb begin
        for (int m = 0; m < NMEM; m++) begin
            sev[m] = go[m] & schk[m].sbe & ~schk[m].mbe;
            mev[m] = go[m] & schk[m].mbe;
        end
        if (urd) begin
            sev[mreq_i.sel] = sev[mreq_i.sel] | (ures.sbe & ~ures.mbe);
            mev[mreq_i.sel] = mev[mreq_i.sel] | ures.mbe;
        end
        ev = 4'h0;
        ev[IRQ_DSB] = sev[MEM_DATA];
        ev[IRQ_DMB] = mev[MEM_DATA];
        ev[IRQ_CSB] = sev[MEM_CODE];
        ev[IRQ_CMB] = mev[MEM_CODE];
    end

    // Sticky status, cleared by a read; a new event wins
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 4'h0;
        end else if (apb_rd && paddr_i == OFF_IRQSTAT) begin
            irq_stat <= ev | (irq_stat & ~prdata_o[IRQ_W-1:0]);
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end

    // Level interrupt from enabled status bits
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_en);
        end
    end

endmodule : medsc_top

`default_nettype wire
